// File: core/chan_adapter_port.sv
// adapter end: status byte, command register and microprogram handshake
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "chan_cmd_map.svh"
module chan_adapter_port
  import chan_cmd_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)(
  input wire logic pclk,
  input wire logic presetn,
  chan_cmd_if.adapter bus,
  input wire logic fifo_not_empty,
  input wire logic chan_sys_reset,
  input wire logic mp_ack,
  input wire logic adapter_idle,
  input wire logic run_wait_edge,
  input wire logic test_mode,
  output logic cmd_strobe,
  output logic [7:0] cmd_q_out,
  output logic [7:0] aux_lba,
  output logic clear_buffers,
  output logic online_ind,
  output logic sim_mode
);
  logic [7:0] cmd_q, aux_q, snap_q, ain_q;
  logic addressed_q, status_mode_q, busy_q, reset_seen_q, illegal_q, modifier_q;
  logic online_q, sim_q, off_pend_q, on_pend_q, strobe_q, inv_q, clr_q;
  logic cmd_ok_q;
  // instruction decode on the host bus
  wire sel = bus.instr_valid && bus.instr_code == `INSTR_SELECT;
  wire stq = bus.instr_valid && bus.instr_code == `INSTR_STATUS;
  wire com = bus.instr_valid && bus.instr_code == `INSTR_COMMAND;
  wire inp = bus.instr_valid && bus.instr_code == `INSTR_INPUT;
  wire sel_hit = sel && bus.a_out == DEV_ADDR;
  // a command counts only when addressed and not busy, others are dropped
  wire accept = com && addressed_q && !busy_q;
  wire cmd_ok, cmd_badseq;
  cmd_decode u_dec (.cmd(bus.a_out), .valid(cmd_ok), .bad_seq(cmd_badseq));
  wire is_mc = bus.a_out[`CMD_MASTER_CLEAR];
  wire is_sc = bus.a_out[`CMD_SYSTEM_CLEAR];
  wire is_on = bus.a_out[`CMD_ON_LINE];
  wire is_off = bus.a_out[`CMD_OFF_LINE];
  // accepted and valid, shared by strobe, clear and on/off-line control
  wire accept_ok = accept && cmd_ok;
  wire clr_now = accept_ok && (is_mc || is_sc);
  wire go_online = on_pend_q && run_wait_edge;
  wire go_offline = off_pend_q && adapter_idle;
  // live status byte
  wire [7:0] live = {1'b0, modifier_q, illegal_q, reset_seen_q, busy_q,
                     fifo_not_empty, online_q, addressed_q};
  // outputs straight from their flops
  assign cmd_strobe = strobe_q;
  assign cmd_q_out = cmd_q;
  assign aux_lba = aux_q;
  assign clear_buffers = clr_q;
  assign online_ind = online_q;
  assign sim_mode = sim_q;
  assign bus.a_in = ain_q;
  assign bus.in_valid = inv_q;
  // address and mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addressed_q <= 1'b0;
      status_mode_q <= 1'b0;
    end
    else if (sel)
    begin
      addressed_q <= sel_hit;
      status_mode_q <= sel_hit;
    end
    else if (stq && addressed_q)
      status_mode_q <= 1'b1;
  end
  // status snapshot and input answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_q <= `STATUS_RESET;
      ain_q <= 8'h00;
      inv_q <= 1'b0;
    end
    else
    begin
      inv_q <= inp && addressed_q && status_mode_q;
      if (sel_hit)
        snap_q <= live | 8'h01;
      else if ((stq || inp) && addressed_q)
        snap_q <= live;
      if (inp && addressed_q && status_mode_q)
        ain_q <= snap_q;
    end
  end
  // command capture and busy handshake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= 8'h00;
      aux_q <= 8'h00;
      busy_q <= 1'b0;
      strobe_q <= 1'b0;
      illegal_q <= 1'b0;
      modifier_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      strobe_q <= accept_ok && !is_on && !is_off;
      clr_q <= clr_now;
      if (accept)
      begin
        cmd_q <= bus.a_out;
        aux_q <= bus.buf_select;
        busy_q <= 1'b1;
        illegal_q <= !cmd_ok;
        modifier_q <= cmd_badseq;
      end
      // busy release depends on the kind of command held
      else if (busy_q)
      begin
        if (cmd_q[`CMD_ON_LINE] && cmd_ok_q)
          busy_q <= !go_online;
        else if (cmd_q[`CMD_OFF_LINE] && cmd_ok_q)
          busy_q <= !go_offline;
        else if (!cmd_ok_q)
          busy_q <= 1'b0;
        else if (mp_ack)
          busy_q <= 1'b0;
      end
    end
  end
  // validity of the command in hand, steers the busy release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_ok_q <= 1'b0;
    else if (accept)
      cmd_ok_q <= cmd_ok;
  end
  // channel reset seen, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_seen_q <= 1'b0;
    else if (chan_sys_reset)
      reset_seen_q <= 1'b1;
    else if (clr_now)
      reset_seen_q <= 1'b0;
  end
  // on-line state and pending transitions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      online_q <= 1'b0;
      sim_q <= 1'b0;
      on_pend_q <= 1'b0;
      off_pend_q <= 1'b0;
    end
    else
    begin
      if (accept_ok && is_on && !online_q)
      begin
        on_pend_q <= 1'b1;
        sim_q <= test_mode;
      end
      else if (go_online)
      begin
        on_pend_q <= 1'b0;
        online_q <= 1'b1;
      end
      if (accept_ok && is_off)
        off_pend_q <= 1'b1;
      else if (go_offline)
      begin
        off_pend_q <= 1'b0;
        online_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/chan_cmd_if.sv
// host bus between the minicomputer side and the adapter command port
`timescale 1ns/1ps
`default_nettype none
interface chan_cmd_if;
  logic instr_valid;
  logic [1:0] instr_code;
  logic [7:0] a_out;
  logic [7:0] buf_select;
  logic [7:0] a_in;
  logic in_valid;
  modport adapter (input instr_valid, input instr_code, input a_out, input buf_select,
    output a_in, output in_valid);
  modport host (output instr_valid, output instr_code, output a_out, output buf_select,
    input a_in, input in_valid);
endinterface
`default_nettype wire

// File: core/chan_cmd_map.svh
// constants for the channel adapter host command port
`ifndef CHAN_CMD_MAP_SVH
`define CHAN_CMD_MAP_SVH
`define DEV_ADDR_DEFAULT 8'h8D
`define ST_ADDRESSED 0
`define ST_ONLINE 1
`define ST_INDEX_AVAIL 2
`define ST_BUSY 3
`define ST_RESET_SEEN 4
`define ST_ILLEGAL 5
`define ST_MODIFIER 6
`define CMD_MASTER_CLEAR 0
`define CMD_CONFIGURE 1
`define CMD_SYSTEM_CLEAR 2
`define CMD_ON_LINE 3
`define CMD_OFF_LINE 4
`define CMD_INIT_SEQ 5
`define CMD_ASYNC_STATUS 6
`define CMD_RESERVED 7
`define STATUS_RESET 8'h00
`define REG_CMD_OFF 12'h000
`define REG_ADDR_OFF 12'h004
`define REG_STAT_OFF 12'h008
`define REG_BSEL_OFF 12'h00C
`define HCTL_GO 0
`define HCTL_BUSY 0
`define HCTL_DONE 1
`define INSTR_SELECT 2'h0
`define INSTR_STATUS 2'h1
`define INSTR_COMMAND 2'h2
`define INSTR_INPUT 2'h3
`endif

// File: core/chan_cmd_pkg.sv
// types shared by both ends of the command port
package chan_cmd_pkg;
  typedef logic [1:0] instr_t;
  typedef logic [7:0] byte_t;
endpackage

// File: core/chan_host_port.sv
// host end: APB slave that issues I/O bus instructions
`timescale 1ns/1ps
`default_nettype none
`include "chan_cmd_map.svh"
module chan_host_port
  import chan_cmd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  chan_cmd_if.host bus
);
  logic iv_q, pend_q, done_q;
  logic [1:0] code_q;
  logic [7:0] aout_q, bsel_q, stat_q;
  logic [31:0] rd_q;
  wire wr = psel && penable && pwrite && !pready;
  wire rd = psel && penable && !pwrite && !pready;
  wire hit_cmd = paddr == `REG_CMD_OFF;
  wire hit_adr = paddr == `REG_ADDR_OFF;
  wire hit_st = paddr == `REG_STAT_OFF;
  wire hit_bs = paddr == `REG_BSEL_OFF;
  wire mapped = hit_cmd || hit_adr || hit_st || hit_bs;
  assign bus.instr_valid = iv_q;
  assign bus.instr_code = code_q;
  assign bus.a_out = aout_q;
  assign bus.buf_select = bsel_q;
  // apb answer, one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= wr || rd;
      pslverr <= (wr || rd) && !mapped;
      prdata <= rd ? rd_q : 32'h00000000;
    end
  end
  // read mux: status byte, handshake flags or buffer select
  always_comb
  begin
    rd_q = 32'h00000000;
    if (hit_st)
      rd_q = {24'h000000, stat_q};
    else if (hit_cmd)
      rd_q = {30'h00000000, done_q, pend_q};
    else if (hit_bs)
      rd_q = {24'h000000, bsel_q};
  end
  // instruction issue: select, command, then status request and input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iv_q <= 1'b0;
      code_q <= `INSTR_SELECT;
      aout_q <= 8'h00;
      bsel_q <= 8'h00;
      pend_q <= 1'b0;
      done_q <= 1'b0;
      stat_q <= 8'h00;
    end
    else
    begin
      iv_q <= 1'b0;
      if (wr && hit_adr)
      begin
        iv_q <= 1'b1;
        code_q <= `INSTR_SELECT;
        aout_q <= pwdata[7:0];
      end
      else if (wr && hit_cmd)
      begin
        iv_q <= 1'b1;
        code_q <= `INSTR_COMMAND;
        aout_q <= pwdata[7:0];
      end
      else if (wr && hit_bs)
        bsel_q <= pwdata[7:0];
      else if (wr && hit_st)
      begin
        iv_q <= 1'b1;
        code_q <= `INSTR_STATUS;
        pend_q <= 1'b1;
        done_q <= 1'b0;
      end
      else if (pend_q && !iv_q && code_q == `INSTR_STATUS)
      begin
        iv_q <= 1'b1;
        code_q <= `INSTR_INPUT;
      end
      if (bus.in_valid && pend_q)
      begin
        stat_q <= bus.a_in;
        pend_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: core/cmd_decode.sv
// one-hot command byte checker
`timescale 1ns/1ps
`default_nettype none
`include "chan_cmd_map.svh"
module cmd_decode
  import chan_cmd_pkg::*;
(
  input wire logic [7:0] cmd,
  output logic valid,
  output logic bad_seq
);
  // exactly one of bits 0..6 set, with bit 7 clear, is a valid command
  wire [6:0] low = cmd[6:0];
  wire one_hot = (low != 7'h00) && ((low & (low - 7'h01)) == 7'h00);
  assign valid = one_hot && !cmd[`CMD_RESERVED];
  assign bad_seq = cmd[`CMD_INIT_SEQ] && !valid;
endmodule
`default_nettype wire

// File: dv/chan_cmd_asserts.sv
// assertions on the instruction bus between host and adapter
`timescale 1ns/1ps
`default_nettype none
`include "chan_cmd_map.svh"
module chan_cmd_asserts
  import chan_cmd_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_valid,
  input wire logic [1:0] instr_code,
  input wire logic [7:0] a_out,
  input wire logic [7:0] buf_select,
  input wire logic [7:0] a_in,
  input wire logic in_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic miss_q, bad_q, mod_q;
  // instruction decode
  wire inp = instr_valid && instr_code == `INSTR_INPUT;
  wire sel = instr_valid && instr_code == `INSTR_SELECT;
  wire cmd = instr_valid && instr_code == `INSTR_COMMAND;
  // track addressing and validity of the last command
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      miss_q <= 1'h1;
      bad_q <= 1'h0;
      mod_q <= 1'h0;
    end
    else
    begin
      if (sel)
        miss_q <= a_out != DEV_ADDR;
      if (cmd && !miss_q)
        bad_q <= $countones(a_out[6:0]) != 1;
      if (cmd && !miss_q)
        mod_q <= $countones(a_out[6:0]) != 1 && a_out[5];
    end
  property p_answer; inp && !miss_q |=> in_valid; endproperty
  a_answer: assert property (p_answer) else $error("input not answered");
  property p_only_input; in_valid |-> $past(inp); endproperty
  a_only_input: assert property (p_only_input) else $error("stray answer");
  property p_quiet; miss_q |-> !in_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer while unselected");
  property p_addr_bit; in_valid |-> a_in[`ST_ADDRESSED]; endproperty
  a_addr_bit: assert property (p_addr_bit) else $error("addressed bit low");
  property p_reserved; in_valid |-> !a_in[7]; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_illegal; in_valid |-> a_in[`ST_ILLEGAL] == bad_q; endproperty
  a_illegal: assert property (p_illegal) else $error("illegal bit wrong");
  property p_modifier; in_valid |-> a_in[`ST_MODIFIER] == mod_q; endproperty
  a_modifier: assert property (p_modifier) else $error("modifier bit wrong");
  property p_status_input;
    instr_valid && instr_code == `INSTR_STATUS |-> ##2 inp;
  endproperty
  a_status_input: assert property (p_status_input) else $error("no input after status");
  property p_one_shot; sel || cmd |=> !instr_valid; endproperty
  a_one_shot: assert property (p_one_shot) else $error("instruction repeated");
  property p_bsel_stable; cmd |-> $stable(buf_select); endproperty
  a_bsel_stable: assert property (p_bsel_stable) else $error("buffer select moved");
  // main scenarios
  c_busy: cover property (in_valid && a_in[`ST_BUSY]);
  c_illegal: cover property (in_valid && a_in[`ST_ILLEGAL]);
  c_miss: cover property (sel && a_out != DEV_ADDR);
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench joining host port and adapter port
`timescale 1ns/1ps
`default_nettype none
`include "chan_cmd_map.svh"
module tb
  import chan_cmd_pkg::*;
;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, cmd_strobe, clr, online_ind, sim_mode;
  logic fifo_ne = '0, sys_rst = '0, mp_ack = '0, idle = '0, rw_edge = '0, test_mode = '0;
  logic mod = '0, ill = '0, rst = '0, onl = '0;
  byte_t cmd_q_out, aux_lba;
  int n_fail = 0, tests_run = 0, n_strobe = 0, n_clr = 0, a;
  // on-line first, so that off-line later finds the adapter on-line
  byte_t cmds[10] = '{8'h08, 8'h04, 8'h01, 8'h02, 8'h21, 8'h20, 8'h40, 8'h10, 8'h80, 8'h00};
  chan_cmd_if bus_i();
  chan_host_port i_chan_host_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(bus_i));
  chan_adapter_port i_chan_adapter_port (.pclk(pclk), .presetn(presetn), .bus(bus_i),
    .fifo_not_empty(fifo_ne), .chan_sys_reset(sys_rst), .mp_ack(mp_ack),
    .adapter_idle(idle), .run_wait_edge(rw_edge), .test_mode(test_mode),
    .cmd_strobe(cmd_strobe), .cmd_q_out(cmd_q_out), .aux_lba(aux_lba),
    .clear_buffers(clr), .online_ind(online_ind), .sim_mode(sim_mode));
  chan_cmd_asserts i_chan_cmd_asserts (.pclk(pclk), .presetn(presetn),
    .instr_valid(bus_i.instr_valid), .instr_code(bus_i.instr_code), .a_out(bus_i.a_out),
    .buf_select(bus_i.buf_select), .a_in(bus_i.a_in), .in_valid(bus_i.in_valid));
  // clock and pulse counters
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    n_strobe += int'(cmd_strobe === 1'h1);
    n_clr += int'(clr === 1'h1);
  end
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, result in rd and er
  task automatic apb(input logic w, input logic [11:0] adr, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= adr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= '0;
    penable <= '0;
    if (pready !== 1'h1)
    begin
      n_fail++;
      print_verdict();
    end
  endtask
  // status request, wait for done, read captured byte
  task automatic status();
    int i;
    i = 0;
    apb(1'h1, `REG_STAT_OFF, '0);
    do
    begin
      apb('0, `REG_CMD_OFF, '0);
      i++;
    end while (rd[`HCTL_DONE] !== 1'h1 && i < 10);
    if (rd[`HCTL_DONE] !== 1'h1)
    begin
      n_fail++;
      print_verdict();
    end
    apb('0, `REG_STAT_OFF, '0);
  endtask
  function automatic byte_t exp_st();
    return {1'h0, mod, ill, rst, 1'h0, fifo_ne, onl, 1'h1};
  endfunction
  // issue one command, finish its handshake, check the outcome
  task automatic do_cmd(input byte_t c);
    byte_t b;
    int s0, c0;
    logic bad;
    b = 8'($urandom);
    bad = $countones(c[6:0]) != 1;
    test_mode <= b[0];
    apb(1'h1, `REG_BSEL_OFF, {24'h0, b});
    s0 = n_strobe;
    c0 = n_clr;
    apb(1'h1, `REG_CMD_OFF, {24'h0, c});
    repeat (2) @(posedge pclk);
    check("cmd_q", cmd_q_out, c);
    check("aux_lba", aux_lba, b);
    ill = bad;
    mod = bad & c[5];
    status();
    check("busy", rd[`ST_BUSY], !bad);
    if (c == 8'h08)
    begin
      apb(1'h1, `REG_CMD_OFF, 32'h2);
      repeat (2) @(posedge pclk);
      check("ignored", cmd_q_out, c);
      rw_edge <= 1'h1;
      @(posedge pclk);
      rw_edge <= '0;
      onl = 1'h1;
    end
    else if (c == 8'h10)
    begin
      check("held", rd[`ST_ONLINE], 1'h1);
      idle <= 1'h1;
      onl = '0;
    end
    else if (!bad)
    begin
      mp_ack <= 1'h1;
      @(posedge pclk);
      mp_ack <= '0;
      rst = rst & !(c[0] | c[2]);
    end
    repeat (2) @(posedge pclk);
    idle <= '0;
    status();
    check("status", rd[7:0], exp_st());
    check("online", online_ind, onl);
    if (c == 8'h08)
      check("sim", sim_mode, test_mode);
    check("strobe", n_strobe - s0, !bad && !c[3] && !c[4]);
    check("clear", n_clr - c0, !bad && (c[0] || c[2]));
  endtask
  // main sequence
  initial
  begin
    void'($urandom(10697));
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h1, 12'h010, '0);
    check("slverr", er, 1'h1);
    apb(1'h1, `REG_ADDR_OFF, {24'h0, `DEV_ADDR_DEFAULT ^ 8'h01});
    apb(1'h1, `REG_CMD_OFF, 32'h40);
    repeat (3) @(posedge pclk);
    check("unaddressed", cmd_q_out, 8'h00);
    check("no strobe", n_strobe, 0);
    apb(1'h1, `REG_ADDR_OFF, {24'h0, `DEV_ADDR_DEFAULT});
    sys_rst <= 1'h1;
    fifo_ne <= 1'h1;
    @(posedge pclk);
    sys_rst <= '0;
    rst = 1'h1;
    status();
    check("status", rd[7:0], exp_st());
    fifo_ne <= '0;
    foreach (cmds[k])
      do_cmd(cmds[k]);
    repeat (4)
    begin
      a = $urandom_range(6, 0);
      do_cmd((8'h01 << a) | (8'h01 << ((a + 1 + $urandom_range(5, 0)) % 7)));
    end
    print_verdict();
  end
endmodule
`default_nettype wire
